// ==== hw/csp_codec_serial_port.sv ====
// Codec serial port: clock dividers, shared shift register, control bank.
// Assumes ref_clk runs at twice the master clock pin rate, so one
// master clock period is two ref_clk cycles.
//
// Contract
// - Gain code selects +6 down to -15 dB
// - Mute bit silences differential output
// - Reference bit picks 1.2 or 2.4 V
// - Buffered reference output enabled by bit
// - One bit per serial clock, MSB first
// - Mode bit picks control or data mode
// - Data mode moves only DAC/ADC samples
// - Mixed mode: MSB flags control or sample
// - Sample event overwrites shared shift register
// - Serial rate bounds words per sample
// - Master divider code gives divide 1 to 5
// - Serial divider gives /8, /4, /2, /1
// - Slowest serial rate limits cascade to two
// - Cascade of up to eight codecs
// - Register writes land on serial falling edge
// - Five 8-bit registers, DAC and ADC words
// - Control word flag, rw, address, select, data
// - Nonzero address decremented and forwarded
// - Read fills data field, word sent out
// - Resets clear registers, take four cycles
`timescale 1ns/1ps
`default_nettype none
module csp_codec_serial_port
  import csp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sdi,
  input wire logic sdifs,
  input wire logic [15:0] adc_sample,
  input wire logic dac_load_enable,
  input wire logic overrun_clear,
  output logic sclk_out,
  output logic sdo,
  output logic output_frame_sync,
  output logic [15:0] dac_sample,
  output logic dac_update,
  output logic adc_taken,
  output logic dac_fifo_ready,
  output logic dac_overrun,
  output logic [2:0] output_gain_sel,
  output logic signed [4:0] output_gain_db,
  output logic output_mute,
  output logic high_reference_select,
  output logic reference_out_enable,
  output logic data_program_select,
  output logic mixed_mode,
  output logic port_in_reset
);

  // ********************************
  // State
  // ********************************
  logic [7:0] ctrl_reg [CSP_NUM_REGS];
  csp_state_t state;
  logic [2:0] mcnt, scnt;
  logic [11:0] samp_cnt;
  logic [3:0] rst_cnt, bit_cnt;
  logic [15:0] shift_reg;
  logic rx_framed, sample_due, fwd_pending;

  // ********************************
  // Register fields
  // ********************************
  wire [7:0] control_reg_a, control_reg_b, crc, control_reg_d;
  wire [2:0] mdiv_code;
  wire [1:0] sclk_code, srate_code;
  wire data_mode, mix_mode;
  // Field taps on the bank
  assign control_reg_a = ctrl_reg[CSP_REG_A];
  assign control_reg_b = ctrl_reg[CSP_REG_B];
  assign crc = ctrl_reg[CSP_REG_C];
  assign control_reg_d = ctrl_reg[CSP_REG_D];
  assign mdiv_code = control_reg_b[CRB_MDIV_LSB +: 3];
  assign sclk_code = control_reg_b[CRB_SCLK_LSB +: 2];
  assign srate_code = control_reg_b[CRB_SRATE_LSB +: 2];
  assign data_mode = control_reg_a[CRA_DATA_MODE_BIT];
  assign mix_mode = control_reg_a[CRA_DATA_MODE_BIT] & control_reg_a[CRA_MIXED_BIT];

  // ********************************
  // Clock dividers
  // ********************************
  wire [2:0] mdiv_last, sdiv_last;
  wire [12:0] samp_len;
  wire [11:0] samp_last;
  wire dm_half, sclk_edge, sclk_rise, sclk_fall, samp_wrap;
  // Master divide: codes above four fall back to divide by one
  assign mdiv_last = (mdiv_code > CSP_MDIV_MAX_CODE) ? 3'h0 : mdiv_code;
  // Serial clock half period in internal half periods
  assign sdiv_last = 3'(4'h8 >> sclk_code) - 3'h1;
  // Sample period grows from 256 up to 2048 internal periods
  assign samp_len = CSP_SAMPLE_HALF_BASE << (2'h3 - srate_code); // /8 sclk at /256 fits two words
  assign samp_last = 12'(samp_len - 13'h0001);
  // Compare with >= so a divider change mid-count cannot hang the counter
  assign dm_half = (mcnt >= mdiv_last);
  assign sclk_edge = dm_half && (scnt >= sdiv_last);
  assign sclk_rise = sclk_edge && !sclk_out;
  assign sclk_fall = sclk_edge && sclk_out;
  assign samp_wrap = dm_half && (samp_cnt >= samp_last);

  // ********************************
  // Inbound word decode
  // ********************************
  wire [15:0] rx_word, fwd_word, dac_word, fifo_out_data;
  wire [2:0] dev_addr, reg_sel;
  wire [7:0] rd_data;
  wire [CSP_NUM_REGS-1:0] wr_en;
  wire dev_zero, is_read, last_bit, act, is_ctrl, is_data, fwd_need, sw_reset;
  wire dac_push, fifo_in_ready, fifo_out_valid, dac_pop;
  // Newest bit enters at the bottom, so the first bit ends up on top
  assign rx_word = {shift_reg[14:0], sdi};
  assign dev_addr = rx_word[CW_DEV_LSB +: 3];
  assign reg_sel = rx_word[CW_SEL_LSB +: 3];
  assign dev_zero = (dev_addr == 3'h0);
  assign is_read = rx_word[CW_RW_BIT];
  assign last_bit = (state == CSP_ST_SHIFT) && sclk_fall && (bit_cnt == CSP_LAST_BIT);
  // A word counts only when the host framed it inside our frame
  assign act = last_bit && rx_framed;
  // Program mode: flag set means control; data mode: only samples
  assign is_ctrl = (!data_mode || mix_mode) && rx_word[CW_FLAG_BIT];
  assign is_data = data_mode && !(mix_mode && rx_word[CW_FLAG_BIT]);
  // Reserved selects read back as zero
  assign rd_data = (reg_sel < 3'(CSP_NUM_REGS)) ? ctrl_reg[reg_sel] : 8'h00;
  // Addressed elsewhere: count down and pass along, else answer a read
  assign fwd_word = !dev_zero ? {rx_word[15:14], 3'(dev_addr - 3'h1), rx_word[10:0]}
                              : {rx_word[15:8], rd_data};
  assign fwd_need = act && is_ctrl && (!dev_zero || is_read);
  assign sw_reset = wr_en[CSP_REG_A] && rx_word[CRA_SW_RESET_BIT];
  // Mixed mode keeps 15 bits and pads the bottom
  assign dac_word = mix_mode ? {rx_word[14:0], 1'b0} : rx_word;
  assign dac_push = act && is_data;
  assign dac_pop = samp_wrap && dac_load_enable;

  // ********************************
  // Outbound word and frame start
  // ********************************
  wire [15:0] adc_word, start_word;
  wire frame_start, sample_take;
  // Mixed mode flags samples with a clear MSB
  assign adc_word = mix_mode ? {1'b0, adc_sample[15:1]} : adc_sample;
  // Frames start only from our own frame sync, never from the host
  assign frame_start = (state == CSP_ST_IDLE) && sclk_rise && (sample_due || fwd_pending);
  assign sample_take = frame_start && sample_due;
  // Sample wins the slot and overwrites a waiting forward word
  assign start_word = sample_due ? adc_word : shift_reg;

  // ********************************
  // DAC buffer
  // ********************************
  // Host words wait here until the sample event loads them
  csp_fifo #(.WIDTH(16), .DEPTH(8)) u_dac_fifo (.ref_clk(ref_clk), .arst_n(arst_n), .in_valid(dac_push),
    .in_ready(fifo_in_ready), .in_data(dac_word), .out_valid(fifo_out_valid), .out_ready(dac_pop),
    .out_data(fifo_out_data));

  // ********************************
  // Control register bank
  // ********************************
  // Write strobes on the serial falling edge; software reset clears the whole bank
  genvar gi;
  generate
    for (gi = 0; gi < CSP_NUM_REGS; gi++)
    begin : g_reg
      assign wr_en[gi] = act && is_ctrl && dev_zero && !is_read && (reg_sel == 3'(gi));
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          ctrl_reg[gi] <= CSP_REG_RESET;
        else if (sw_reset)
          ctrl_reg[gi] <= CSP_REG_RESET;
        else if (wr_en[gi])
          ctrl_reg[gi] <= rx_word[7:0];
      end
    end
  endgenerate

  // ********************************
  // Divider counters
  // ********************************
  // Serial clock runs free, so the host always sees a clock
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mcnt <= 3'h0;
      scnt <= 3'h0;
      samp_cnt <= 12'h000;
      sclk_out <= 1'b0;
    end
    else
    begin
      mcnt <= dm_half ? 3'h0 : 3'(mcnt + 3'h1);
      if (dm_half)
        scnt <= sclk_edge ? 3'h0 : 3'(scnt + 3'h1);
      if (dm_half)
        samp_cnt <= samp_wrap ? 12'h000 : 12'(samp_cnt + 12'h001);
      if (sclk_edge)
        sclk_out <= !sclk_out;
    end
  end

  // ********************************
  // Port sequencer
  // ********************************
  // Reset hold counts internal half periods: four full internal cycles
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= CSP_ST_RESET;
      rst_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      rx_framed <= 1'b0;
    end
    else if (sw_reset)
    begin
      state <= CSP_ST_RESET;
      rst_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      rx_framed <= 1'b0;
    end
    else
    begin
      case (state)
        CSP_ST_RESET:
        begin
          if (dm_half)
            rst_cnt <= 4'(rst_cnt + 4'h1);
          if (dm_half && rst_cnt == CSP_RESET_HALF_LAST)
            state <= CSP_ST_IDLE;
        end
        CSP_ST_IDLE:
        begin
          bit_cnt <= 4'h0;
          if (frame_start)
            state <= CSP_ST_SHIFT;
        end
        CSP_ST_SHIFT:
        begin
          if (sclk_fall)
          begin
            bit_cnt <= 4'(bit_cnt + 4'h1);
            if (bit_cnt == 4'h0)
              rx_framed <= sdifs;
            if (bit_cnt == CSP_LAST_BIT)
              state <= CSP_ST_IDLE;
          end
        end
        default:
          state <= CSP_ST_IDLE;
      endcase
    end
  end

  // ********************************
  // Shared shift register
  // ********************************
  // One register for both directions; inbound replaces outbound bit by bit
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      shift_reg <= CSP_WORD_RESET;
    else if (frame_start)
      shift_reg <= start_word;
    else if (fwd_need)
      shift_reg <= fwd_word;
    else if (state == CSP_ST_SHIFT && sclk_fall)
      shift_reg <= rx_word;
  end

  // Pending sample and forward requests; a new sample beats the consume
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sample_due <= 1'b0;
      fwd_pending <= 1'b0;
    end
    else
    begin
      sample_due <= !sw_reset && (samp_wrap || (sample_due && !sample_take));
      fwd_pending <= !sw_reset && (fwd_need || (fwd_pending && !frame_start));
    end
  end

  // ********************************
  // Serial output pins
  // ********************************
  // Drive on the rising edge so the host samples on the falling one
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sdo <= 1'b0;
      output_frame_sync <= 1'b0;
    end
    else if (sclk_rise)
    begin
      sdo <= frame_start ? start_word[15] : ((state == CSP_ST_SHIFT) ? shift_reg[15] : 1'b0);
      output_frame_sync <= frame_start;
    end
  end

  // ********************************
  // DAC load and buffer status
  // ********************************
  // Without a fresh word the previous sample simply stays
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dac_sample <= CSP_WORD_RESET;
      dac_update <= 1'b0;
      adc_taken <= 1'b0;
      dac_fifo_ready <= 1'b0;
      dac_overrun <= 1'b0;
    end
    else
    begin
      if (dac_pop && fifo_out_valid)
        dac_sample <= fifo_out_data;
      dac_update <= dac_pop && fifo_out_valid;
      adc_taken <= sample_take;
      dac_fifo_ready <= fifo_in_ready;
      // A word arriving to a full buffer is dropped; set beats clear
      dac_overrun <= (dac_push && !fifo_in_ready) || (dac_overrun && !overrun_clear);
    end
  end

  // ********************************
  // Analog control decode
  // ********************************
  wire signed [4:0] next_gain_db;
  // Each code step lowers the gain by 3 dB
  assign next_gain_db = CSP_GAIN_TOP_DB - 5'(3 * control_reg_d[CRD_GAIN_LSB +: 3]);

  // Registered copies for the analog section
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      output_gain_sel <= 3'h0;
      output_gain_db <= CSP_GAIN_TOP_DB;
      output_mute <= 1'b0;
      high_reference_select <= 1'b0;
      reference_out_enable <= 1'b0;
      data_program_select <= 1'b0;
      mixed_mode <= 1'b0;
      port_in_reset <= 1'b1;
    end
    else
    begin
      output_gain_sel <= control_reg_d[CRD_GAIN_LSB +: 3];
      output_gain_db <= next_gain_db;
      output_mute <= control_reg_d[CRD_MUTE_BIT];
      high_reference_select <= crc[CRC_HIGH_REF_BIT];
      reference_out_enable <= crc[CRC_REF_OUT_BIT];
      data_program_select <= data_mode;
      mixed_mode <= mix_mode;
      port_in_reset <= (state == CSP_ST_RESET) || sw_reset;
    end
  end

endmodule
`default_nettype wire

// ==== hw/csp_pkg.sv ====
// Shared constants of the codec serial port and its clock dividers.
// Assumes one reference clock at twice the master clock pin rate.
package csp_pkg;

  // ********************************
  // Control register bank
  // ********************************
  localparam int CSP_NUM_REGS = 5;
  localparam logic [2:0] CSP_REG_A = 3'h0;
  localparam logic [2:0] CSP_REG_B = 3'h1;
  localparam logic [2:0] CSP_REG_C = 3'h2;
  localparam logic [2:0] CSP_REG_D = 3'h3;
  localparam logic [7:0] CSP_REG_RESET = 8'h00;

  // Field positions
  localparam int CRA_DATA_MODE_BIT = 0;
  localparam int CRA_MIXED_BIT = 1;
  localparam int CRA_SW_RESET_BIT = 7;
  localparam int CRB_SRATE_LSB = 0;
  localparam int CRB_SCLK_LSB = 2;
  localparam int CRB_MDIV_LSB = 4;
  localparam int CRC_REF_OUT_BIT = 6;
  localparam int CRC_HIGH_REF_BIT = 7;
  localparam int CRD_GAIN_LSB = 4;
  localparam int CRD_MUTE_BIT = 7;

  // Control word layout
  localparam int CW_FLAG_BIT = 15;
  localparam int CW_RW_BIT = 14;
  localparam int CW_DEV_LSB = 11;
  localparam int CW_SEL_LSB = 8;

  // ********************************
  // Clocking and timing
  // ********************************
  localparam int CSP_REF_CLK_HZ = 20_000_000;
  localparam int CSP_RESET_DIVIDED_DEVICE_CLOCK = 4;
  localparam logic [3:0] CSP_RESET_HALF_LAST = 4'(2 * CSP_RESET_DIVIDED_DEVICE_CLOCK - 1);
  localparam logic [2:0] CSP_MDIV_MAX_CODE = 3'h4;
  localparam logic [12:0] CSP_SAMPLE_HALF_BASE = 13'h0200;
  localparam logic [3:0] CSP_LAST_BIT = 4'hF;
  localparam logic signed [4:0] CSP_GAIN_TOP_DB = 5'sh06;
  localparam logic [15:0] CSP_WORD_RESET = 16'h0000;

  // ********************************
  // Port sequencer states
  // ********************************
  typedef enum logic [1:0] {
    CSP_ST_IDLE = 2'b00,
    CSP_ST_SHIFT = 2'b01,
    CSP_ST_RESET = 2'b10
  } csp_state_t;

endpackage

// ==== hw/csp_fifo.sv ====
// Small FIFO with registered read data, valid and ready on both sides.
// Assumes DEPTH is a power of two; pointers wrap naturally.
`timescale 1ns/1ps
`default_nettype none
module csp_fifo
  import csp_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push;
  wire pop;
  wire [AW-1:0] next_rd_ptr;

  // Handshake terms
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;

  // Storage carries no reset to keep it a plain memory
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers, fill level and head register; bypass when the head is being written
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_data <= '0;
    end
    else
    begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= (AW+1)'(count + push - pop);
      out_data <= (push && wr_ptr == next_rd_ptr) ? in_data : mem[next_rd_ptr];
    end
  end

endmodule
`default_nettype wire

// ==== sim/csp_port_monitor.sv ====
// Concurrent checks on the codec serial port top-level ports.
// Assumes one ref_clk domain and the asynchronous active-low arst_n.
`timescale 1ns/1ps
`default_nettype none
module csp_port_monitor
  import csp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic dac_load_enable,
  input wire logic sclk_out,
  input wire logic sdo,
  input wire logic output_frame_sync,
  input wire logic dac_update,
  input wire logic adc_taken,
  input wire logic dac_overrun,
  input wire logic [2:0] output_gain_sel,
  input wire logic signed [4:0] output_gain_db,
  input wire logic output_mute,
  input wire logic data_program_select,
  input wire logic mixed_mode,
  input wire logic port_in_reset
);
  // ************************
  // Properties
  // ************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // Gain decode is held apart from the reset hold, where outputs may lag the bank
  property p_gain; !port_in_reset |-> output_gain_db == CSP_GAIN_TOP_DB - 5'(3 * output_gain_sel); endproperty
  property p_mixed; mixed_mode |-> data_program_select; endproperty
  property p_sync_edge; $rose(output_frame_sync) |-> $rose(sclk_out); endproperty
  property p_sdo_edge; $changed(sdo) |-> $rose(sclk_out); endproperty
  property p_update_pulse; dac_update |=> !dac_update; endproperty
  property p_update_cause; dac_update |-> $past(dac_load_enable) || $past(dac_load_enable, 2); endproperty
  // Longest hold is four internal cycles at divide by five
  property p_hold_ends; port_in_reset |-> ##[0:48] !port_in_reset; endproperty
  property p_reset_clear; $fell(port_in_reset) |-> output_gain_sel == 3'h0 && !output_mute && !data_program_select;
  endproperty
  property p_taken_frame; adc_taken |-> ##[0:1] output_frame_sync; endproperty
  a_gain: assert property (p_gain) else $error("gain in dB does not follow gain code");
  a_mixed: assert property (p_mixed) else $error("mixed mode without data mode");
  a_sync_edge: assert property (p_sync_edge) else $error("frame sync rose off sclk rise");
  a_sdo_edge: assert property (p_sdo_edge) else $error("sdo changed off sclk rise");
  a_update_pulse: assert property (p_update_pulse) else $error("dac update longer than one cycle");
  a_update_cause: assert property (p_update_cause) else $error("dac update while load disabled");
  a_hold_ends: assert property (p_hold_ends) else $error("reset hold too long");
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");
  a_taken_frame: assert property (p_taken_frame) else $error("sample taken without frame sync");
  c_update: cover property (dac_update);
  c_taken: cover property (adc_taken);
  c_overrun: cover property (dac_overrun);
  c_hold: cover property ($fell(port_in_reset));
endmodule
bind csp_codec_serial_port csp_port_monitor u_csp_port_monitor (.ref_clk(ref_clk), .arst_n(arst_n),
  .dac_load_enable(dac_load_enable), .sclk_out(sclk_out), .sdo(sdo), .output_frame_sync(output_frame_sync),
  .dac_update(dac_update), .adc_taken(adc_taken), .dac_overrun(dac_overrun), .output_gain_sel(output_gain_sel),
  .output_gain_db(output_gain_db), .output_mute(output_mute), .data_program_select(data_program_select),
  .mixed_mode(mixed_mode), .port_in_reset(port_in_reset));
`default_nettype wire

// ==== sim/csp_host_model.sv ====
// Host serial port model: joins only frames that the codec opens.
// Assumes sclk half periods of at least two ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module csp_host_model
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk_out,
  input wire logic output_frame_sync,
  input wire logic sdo,
  input wire logic tx_arm,
  input wire logic [15:0] tx_word,
  output logic sdi,
  output logic sdifs,
  output logic [15:0] rx_word,
  output logic rx_done
);
  // ************************
  // Frame follower
  // ************************
  logic sclk_q, busy, sending;
  logic [15:0] tx_sr;
  logic [3:0] rx_cnt;
  wire logic sclk_rise = sclk_out & ~sclk_q;
  wire logic sclk_fall = ~sclk_out & sclk_q;
  // Idle sdi toggles each sclk so a stale bit never passes for data
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_q <= 1'b0;
      busy <= 1'b0;
      sending <= 1'b0;
      sdi <= 1'b0;
      sdifs <= 1'b0;
      tx_sr <= 16'h0000;
      rx_cnt <= 4'h0;
      rx_word <= 16'h0000;
      rx_done <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_out;
      rx_done <= 1'b0;
      // One codec, one word a frame: inside cascade and rate limits
      if (sclk_rise && output_frame_sync && !busy)
      begin
        busy <= 1'b1;
        sending <= tx_arm;
        sdifs <= tx_arm;
        sdi <= tx_arm ? tx_word[15] : ~sdi;
        tx_sr <= {tx_word[14:0], 1'b0};
      end
      else if (sclk_rise)
      begin
        sdifs <= 1'b0;
        sdi <= sending ? tx_sr[15] : ~sdi;
        tx_sr <= {tx_sr[14:0], 1'b0};
      end
      if (sclk_fall && busy)
      begin
        rx_word <= {rx_word[14:0], sdo};
        rx_cnt <= rx_cnt + 4'h1;
        busy <= (rx_cnt != 4'hF);
        sending <= sending && (rx_cnt != 4'hF);
        rx_done <= (rx_cnt == 4'hF);
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/codec_serial_port_clocking_bench.sv ====
// Self-checking bench for the codec serial port and its clock dividers.
// Assumes the host model on the link and the bound port monitor.
`timescale 1ns/1ps
`default_nettype none
module codec_serial_port_clocking_bench
  import csp_pkg::*;
;
  // ************************
  // Signals and instances
  // ************************
  logic ref_clk, arst_n, sdi, sdifs, dac_load_enable, overrun_clear, tx_arm, rx_done, sclk_out, sdo;
  logic output_frame_sync, dac_update, adc_taken, dac_fifo_ready, dac_overrun, output_mute, mixed_mode;
  logic high_reference_select, reference_out_enable, data_program_select, port_in_reset;
  logic [15:0] adc_sample, tx_word, rx_word, dac_sample;
  logic [2:0] output_gain_sel;
  logic signed [4:0] output_gain_db;
  int err_count, total_checks, w, a, b;
  csp_codec_serial_port u_csp_codec_serial_port (.ref_clk(ref_clk), .arst_n(arst_n), .sdi(sdi), .sdifs(sdifs),
    .adc_sample(adc_sample), .dac_load_enable(dac_load_enable), .overrun_clear(overrun_clear),
    .sclk_out(sclk_out), .sdo(sdo), .output_frame_sync(output_frame_sync), .dac_sample(dac_sample),
    .dac_update(dac_update), .adc_taken(adc_taken), .dac_fifo_ready(dac_fifo_ready), .dac_overrun(dac_overrun),
    .output_gain_sel(output_gain_sel), .output_gain_db(output_gain_db), .output_mute(output_mute),
    .high_reference_select(high_reference_select), .reference_out_enable(reference_out_enable),
    .data_program_select(data_program_select), .mixed_mode(mixed_mode), .port_in_reset(port_in_reset));
  csp_host_model u_csp_host_model (.ref_clk(ref_clk), .arst_n(arst_n), .sclk_out(sclk_out),
    .output_frame_sync(output_frame_sync), .sdo(sdo), .tx_arm(tx_arm), .tx_word(tx_word), .sdi(sdi),
    .sdifs(sdifs), .rx_word(rx_word), .rx_done(rx_done));
  // ************************
  // Shared tasks
  // ************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait; a hang ends the run rather than stalling it
  task automatic wait_lvl(ref logic sig, input logic lvl, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge ref_clk);
      cnt++;
    end
    while (sig !== lvl && cnt < 20000);
    if (cnt >= 20000)
    begin
      chk("wait limit", 16'h0000, 16'h0001);
      finish_test();
    end
  endtask
  task automatic xfer(input logic [15:0] word);
    tx_word <= word;
    tx_arm <= 1'b1;
    wait_lvl(rx_done, 1'b1, w);
    tx_arm <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    xfer({2'b10, 3'b000, sel, d});
    repeat (4) @(posedge ref_clk);
  endtask
  // ************************
  // Scenarios
  // ************************
  task automatic t_reset();
    wait_lvl(port_in_reset, 1'b0, a);
    chk("hold length", 16'(a), 16'(2 * CSP_RESET_DIVIDED_DEVICE_CLOCK + 2));
    chk("gain_db", 16'(output_gain_db), 16'h0006);
    chk("flags", {output_mute, high_reference_select, reference_out_enable, data_program_select}, 16'h0000);
    wr(CSP_REG_B, 8'h07);
    $display("test reset done");
  endtask
  task automatic t_gain();
    for (int c = 0; c < 8; c++)
    begin
      wr(CSP_REG_D, {1'b0, 3'(c), 4'h0});
      chk("gain_sel", 16'(output_gain_sel), 16'(c));
      chk("gain_db", 16'(output_gain_db), 16'(6 - 3 * c));
    end
    wr(CSP_REG_D, 8'hF0);
    chk("mute on", 16'(output_mute), 16'h0001);
    xfer(16'hC300);
    wait_lvl(rx_done, 1'b1, w);
    chk("read reply", rx_word, 16'hC3F0);
    wr(CSP_REG_D, 8'h70);
    chk("mute off", 16'(output_mute), 16'h0000);
    for (int c = 0; c < 4; c++)
    begin
      wr(CSP_REG_C, {2'(c), 6'h00});
      chk("high ref", 16'(high_reference_select), 16'(c / 2));
      chk("ref out", 16'(reference_out_enable), 16'(c % 2));
    end
    xfer(16'h935A);
    wait_lvl(rx_done, 1'b1, w);
    chk("forwarded", rx_word, 16'h8B5A);
    chk("not for us", 16'(output_gain_sel), 16'h0007);
    $display("test control done");
  endtask
  task automatic t_modes();
    wr(CSP_REG_A, 8'h80);
    wait_lvl(port_in_reset, 1'b0, w);
    chk("soft reset", {output_gain_sel, high_reference_select}, 16'h0000);
    wr(CSP_REG_B, 8'h07);
    wr(CSP_REG_A, 8'h03);
    chk("mixed", {data_program_select, mixed_mode}, 16'h0003);
    xfer(16'h1234);
    chk("adc mixed", rx_word, 16'h52E1);
    wait_lvl(dac_update, 1'b1, w);
    chk("dac mixed", dac_sample, 16'h2468);
    xfer(16'h8001);
    repeat (4) @(posedge ref_clk);
    chk("data mode", {data_program_select, mixed_mode}, 16'h0002);
    xfer(16'h8370);
    chk("adc data", rx_word, 16'hA5C3);
    wait_lvl(dac_update, 1'b1, w);
    chk("dac data", dac_sample, 16'h8370);
    chk("no control", 16'(output_gain_sel), 16'h0000);
    $display("test modes done");
  endtask
  task automatic t_fifo();
    dac_load_enable <= 1'b0;
    for (int i = 0; i < 9; i++)
      xfer(16'h1000 + 16'(i));
    chk("full", {dac_overrun, dac_fifo_ready}, 16'h0002);
    overrun_clear <= 1'b1;
    @(posedge ref_clk);
    overrun_clear <= 1'b0;
    dac_load_enable <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("cleared", 16'(dac_overrun), 16'h0000);
    for (int k = 0; k < 8; k++)
    begin
      wait_lvl(dac_update, 1'b1, w);
      chk("drain", dac_sample, 16'h1000 + 16'(k));
    end
    chk("ready", 16'(dac_fifo_ready), 16'h0001);
    $display("test fifo done");
  endtask
  // Fastest serial clock goes last: the host model cannot follow one-cycle halves
  task automatic t_clk();
    logic [4:0] cfg [5] = '{5'h10, 5'h09, 5'h1E, 5'h07, 5'h03};
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    wait_lvl(port_in_reset, 1'b0, w);
    for (int i = 0; i < 5; i++)
    begin
      wr(CSP_REG_B, {1'b0, cfg[i], 2'b11});
      repeat (3)
      begin
        wait_lvl(sclk_out, 1'b0, w);
        wait_lvl(sclk_out, 1'b1, w);
      end
      wait_lvl(sclk_out, 1'b0, a);
      wait_lvl(sclk_out, 1'b1, b);
      w = (cfg[i][4:2] <= 3'h4) ? 32'(cfg[i][4:2]) + 1 : 1;
      chk("sclk period", 16'(a + b), 16'(2 * w * (8 >> cfg[i][1:0])));
    end
    $display("test clocks done");
  endtask
  // ************************
  // Clock and main sequence
  // ************************
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    err_count = 0;
    total_checks = 0;
    arst_n = 1'b0;
    tx_arm = 1'b0;
    tx_word = 16'h0000;
    dac_load_enable = 1'b1;
    overrun_clear = 1'b0;
    adc_sample = 16'hA5C3;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_gain();
    t_modes();
    t_fifo();
    t_clk();
    finish_test();
  end
endmodule
`default_nettype wire
